// File: core/topc_pkg.sv
package topc_pkg;
    // ==========================================================
    // register addresses
    localparam logic [15:0] ADDR_PORT_DIR = 16'hff22;
    localparam logic [15:0] ADDR_PRESCALE = 16'hff61;
    localparam logic [15:0] ADDR_OUT_CTRL = 16'hff63;
    // ==========================================================
    // reset values
    localparam logic [7:0] RST_PORT_DIR = 8'hff;
    localparam logic [7:0] RST_PRESCALE = 8'h00;
    localparam logic [7:0] RST_OUT_CTRL = 8'h00;
    // port direction: bits 7:4 read as one, bits 3:0 writable
    localparam logic [7:0] PORT_DIR_FIXED = 8'hf0;
    localparam logic [7:0] PORT_DIR_WMASK = 8'h0f;
    // ==========================================================
    // output control field positions
    localparam int OC_ENABLE = 0;
    localparam int OC_INV_FIRST = 1;
    localparam int OC_PRESET_CLR = 2;
    localparam int OC_PRESET_SET = 3;
    localparam int OC_INV_SECOND = 4;
    localparam int OC_ONESHOT_MODE = 5;
    localparam int OC_ONESHOT_TRIG = 6;
    // output control bits that hold state (preset and trigger read zero)
    localparam logic [7:0] OC_STORE_MASK = 8'h33;
    // ==========================================================
    // prescale / edge field positions
    localparam int PR_CLK_LO = 0;
    localparam int PR_FIRST_EDGE_LO = 4;
    localparam int PR_SECOND_EDGE_LO = 6;
    localparam logic [7:0] PR_STORE_MASK = 8'hf3;
    // edge select codes
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // count clock codes
    localparam logic [1:0] CLK_DIV1 = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV256 = 2'h2;
    localparam logic [1:0] CLK_PIN = 2'h3;
    localparam int DIV_A = 4;
    localparam int DIV_B = 256;
    // counter mode codes (upper two bits of the mode field)
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_PIN_CLEAR = 2'h2;
    localparam logic [1:0] MODE_MATCH_CLEAR = 2'h3;
    // ==========================================================
    // register bus request carrier
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } topc_bus_t;
    // timer events from the counter core
    typedef struct packed {
        logic match_first;
        logic match_second;
        logic overflow;
    } topc_evt_t;
endpackage

// File: core/topc_edge_det.sv
module topc_edge_det
(
    input wire logic clk,
    input wire logic srst,
    input wire logic pin,
    input wire logic run,
    input wire logic sample_en,
    input wire logic [1:0] edge_sel,
    output logic edge_hit
);
    // ==========================================================
    // two-flop synchroniser; only the second stage is read
    logic sync1_q;
    logic sync2_q;
    logic samp1_q;
    logic level_q;
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= pin;
            sync2_q <= sync1_q;
        end
    end
    // ==========================================================
    // noise filter: level taken after two equal samples.
    // the held level only moves while running, so a level change during
    // stop shows as an edge at the second sample after enable
    wire stable = (samp1_q == sync2_q);
    wire changed = stable && (sync2_q != level_q);
    wire rise_ok = (edge_sel == topc_pkg::EDGE_RISE)
                || (edge_sel == topc_pkg::EDGE_BOTH);
    wire fall_ok = (edge_sel == topc_pkg::EDGE_FALL)
                || (edge_sel == topc_pkg::EDGE_BOTH);
    wire hit = run && sample_en && changed
             && (sync2_q ? rise_ok : fall_ok);
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            samp1_q <= 1'b0;
            level_q <= 1'b0;
            edge_hit <= 1'b0;
        end
        else
        begin
            edge_hit <= hit;
            if (run && sample_en)
            begin
                samp1_q <= sync2_q;
                if (changed)
                    level_q <= sync2_q;
            end
        end
    end
endmodule // topc_edge_det

// File: core/topc_ctrl.sv
// Overview of operation
// - one-shot trigger bit fires, reads zero
// - one-shot mode bit selects single pulse
// - one-shot only in free-run or pin-clear
// - second match toggles output when enabled
// - first match toggles output when enabled
// - preset field: keep, clear, set; 11 forbidden
// - preset bits always read zero
// - output disabled holds pin low
// - second pin edge: fall, rise, both
// - first pin edge: fall, rise, both
// - count clock: div 1, 4, 256, pin
// - level change during stop detected at enable
// - edges need two equal samples
// - shared pin is input or output by direction
// - mode field decodes stop, free, pin, match
module topc_ctrl
#(
    parameter int DIV_A = topc_pkg::DIV_A,
    parameter int DIV_B = topc_pkg::DIV_B
)
(
    input wire logic CLK,
    input wire logic SRST,
    input wire topc_pkg::topc_bus_t BUS,
    output logic [7:0] RDATA,
    input wire logic [2:0] MODE_FIELD,
    input wire topc_pkg::topc_evt_t EVT,
    input wire logic FIRST_PIN,
    input wire logic SHARED_PIN_IN,
    output logic SHARED_PIN_OUT,
    output logic SHARED_PIN_OE_N,
    output logic [7:0] PORT_DIR,
    output logic COUNT_EN,
    output logic FIRST_EDGE,
    output logic SECOND_EDGE
);
    // ==========================================================
    // registers
    logic [7:0] port_dir_q;
    logic [7:0] prescale_q;
    logic [7:0] out_ctrl_q;
    logic out_ff_q;
    logic [7:0] div_q;
    wire sel_dir = BUS.addr == topc_pkg::ADDR_PORT_DIR;
    wire sel_pre = BUS.addr == topc_pkg::ADDR_PRESCALE;
    wire sel_oc = BUS.addr == topc_pkg::ADDR_OUT_CTRL;
    wire wr_dir = BUS.wr && sel_dir;
    wire wr_pre = BUS.wr && sel_pre;
    wire wr_oc = BUS.wr && sel_oc;
    // ==========================================================
    // mode decode
    wire [1:0] mode_hi = MODE_FIELD[2:1];
    wire running = mode_hi != topc_pkg::MODE_STOP;
    wire pin_toggle = MODE_FIELD[0] && running;
    wire oneshot_ok = (mode_hi == topc_pkg::MODE_FREE)
                   || (mode_hi == topc_pkg::MODE_PIN_CLEAR);
    // ==========================================================
    // prescaler; divider rests at zero while stopped
    wire [1:0] clk_sel = prescale_q[topc_pkg::PR_CLK_LO +: 2];
    // ratios must be powers of two no larger than 256: the divider is 8 bits
    localparam logic [7:0] MASK_A = 8'(DIV_A - 1);
    localparam logic [7:0] MASK_B = 8'(DIV_B - 1);
    wire tick_a = ((div_q & MASK_A) == MASK_A);
    wire tick_b = ((div_q & MASK_B) == MASK_B);
    wire pin_clock = clk_sel == topc_pkg::CLK_PIN;
    wire first_hit;
    wire second_hit;
    logic presc_tick;
    always_comb
    begin
        case (clk_sel)
            topc_pkg::CLK_DIV1: presc_tick = running;
            topc_pkg::CLK_DIV4: presc_tick = running && tick_a;
            topc_pkg::CLK_DIV256: presc_tick = running && tick_b;
            default: presc_tick = first_hit;
        endcase
    end
    assign COUNT_EN = presc_tick;
    // pin clock mode samples at the full rate, capture use at count rate
    wire first_samp = pin_clock ? 1'b1 : presc_tick;
    always_ff @(posedge CLK)
    begin
        if (SRST || !running)
            div_q <= 8'h00;
        else
            div_q <= div_q + 8'h01;
    end
    // ==========================================================
    // edge detectors on both input pins
    wire second_in_mode = port_dir_q[1];
    topc_edge_det u_first
    (
        .clk(CLK),
        .srst(SRST),
        .pin(FIRST_PIN),
        .run(running),
        .sample_en(first_samp),
        .edge_sel(prescale_q[topc_pkg::PR_FIRST_EDGE_LO +: 2]),
        .edge_hit(first_hit)
    );
    topc_edge_det u_second
    (
        .clk(CLK),
        .srst(SRST),
        .pin(SHARED_PIN_IN),
        .run(running && second_in_mode),
        .sample_en(presc_tick),
        .edge_sel(prescale_q[topc_pkg::PR_SECOND_EDGE_LO +: 2]),
        .edge_hit(second_hit)
    );
    assign FIRST_EDGE = first_hit;
    assign SECOND_EDGE = second_hit;
    // ==========================================================
    // output flip-flop
    wire oc_en = out_ctrl_q[topc_pkg::OC_ENABLE];
    wire inv1 = out_ctrl_q[topc_pkg::OC_INV_FIRST]
             && EVT.match_first;
    wire inv2 = out_ctrl_q[topc_pkg::OC_INV_SECOND]
             && EVT.match_second;
    wire invp = pin_toggle && first_hit && !pin_clock;
    wire os_mode = out_ctrl_q[topc_pkg::OC_ONESHOT_MODE];
    wire trig = wr_oc && BUS.wdata[topc_pkg::OC_ONESHOT_TRIG]
             && os_mode && oneshot_ok;
    wire pset = wr_oc && BUS.wdata[topc_pkg::OC_PRESET_SET]
             && !BUS.wdata[topc_pkg::OC_PRESET_CLR];
    wire pclr = wr_oc && BUS.wdata[topc_pkg::OC_PRESET_CLR]
             && !BUS.wdata[topc_pkg::OC_PRESET_SET];
    // one-shot: trigger arms, first-compare match sets, second-compare match ends the pulse
    logic os_arm_q;
    wire toggle = os_mode ? 1'b0 : (inv1 ^ inv2 ^ invp);
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            out_ff_q <= 1'b0;
            os_arm_q <= 1'b0;
        end
        else if (pset)
            out_ff_q <= 1'b1;
        else if (pclr)
            out_ff_q <= 1'b0;
        else if (os_mode)
        begin
            if (trig)
                os_arm_q <= 1'b1;
            else if (os_arm_q && inv1 && oneshot_ok)
            begin
                out_ff_q <= 1'b1;
                os_arm_q <= 1'b0;
            end
            else if (out_ff_q && inv2)
                out_ff_q <= 1'b0;
        end
        else if (toggle)
            out_ff_q <= ~out_ff_q;
    end
    // ==========================================================
    // register writes; preset and trigger bits are not stored
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            port_dir_q <= topc_pkg::RST_PORT_DIR;
            prescale_q <= topc_pkg::RST_PRESCALE;
            out_ctrl_q <= topc_pkg::RST_OUT_CTRL;
        end
        else
        begin
            if (wr_dir)
                port_dir_q <= topc_pkg::PORT_DIR_FIXED
                            | (BUS.wdata & topc_pkg::PORT_DIR_WMASK);
            if (wr_pre)
                prescale_q <= BUS.wdata & topc_pkg::PR_STORE_MASK;
            if (wr_oc)
                out_ctrl_q <= BUS.wdata & topc_pkg::OC_STORE_MASK;
        end
    end
    // ==========================================================
    // read data, registered
    wire [7:0] rd_mux = sel_dir ? port_dir_q
                      : sel_pre ? prescale_q
                      : sel_oc ? out_ctrl_q
                      : 8'h00;
    always_ff @(posedge CLK)
    begin
        if (SRST)
            RDATA <= 8'h00;
        else if (BUS.rd)
            RDATA <= rd_mux;
    end
    // ==========================================================
    // pins: output only when direction bit is zero
    always_ff @(posedge CLK)
    begin
        if (SRST)
            SHARED_PIN_OUT <= 1'b0;
        else
            SHARED_PIN_OUT <= oc_en ? out_ff_q : 1'b0;
    end
    assign SHARED_PIN_OE_N = second_in_mode;
    assign PORT_DIR = port_dir_q;
    // ==========================================================
    // checks
    a_preset_reads_zero: assert property (@(posedge CLK) disable iff (SRST)
        out_ctrl_q[3:2] == 2'h0)
        else $error("preset bits stored");
    a_trig_reads_zero: assert property (@(posedge CLK) disable iff (SRST)
        out_ctrl_q[topc_pkg::OC_ONESHOT_TRIG] == 1'b0)
        else $error("trigger bit stored");
    a_disabled_low: assert property (@(posedge CLK) disable iff (SRST)
        !oc_en |=> !SHARED_PIN_OUT)
        else $error("pin not low when disabled");
    a_preset_sets: assert property (@(posedge CLK) disable iff (SRST)
        pset |=> out_ff_q)
        else $error("preset set failed");
    a_preset_clears: assert property (@(posedge CLK) disable iff (SRST)
        pclr |=> !out_ff_q)
        else $error("preset clear failed");
    a_first_toggle: assert property (@(posedge CLK) disable iff (SRST)
        !pset && !pclr && !os_mode && inv1 && !inv2 && !invp
        |=> out_ff_q != $past(out_ff_q))
        else $error("first match no toggle");
    a_second_toggle: assert property (@(posedge CLK) disable iff (SRST)
        !pset && !pclr && !os_mode && !inv1 && inv2 && !invp
        |=> out_ff_q != $past(out_ff_q))
        else $error("second match no toggle");
    a_no_toggle_off: assert property (@(posedge CLK) disable iff (SRST)
        !pset && !pclr && !os_mode && !inv1 && !inv2 && !invp
        |=> $stable(out_ff_q))
        else $error("spurious toggle");
    a_div4_rate: assert property (@(posedge CLK) disable iff (SRST)
        running && clk_sel == topc_pkg::CLK_DIV4 && presc_tick
        && $stable(clk_sel) ##1 $stable(clk_sel) && running
        |-> !presc_tick)
        else $error("div4 tick too soon");
    a_stop_no_edge: assert property (@(posedge CLK) disable iff (SRST)
        !running |=> !first_hit)
        else $error("edge while stopped");
endmodule // topc_ctrl

// File: verification/topc_pin_src.sv
module topc_pin_src
(
    input wire logic clk,
    output logic first_pin,
    output logic second_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        first_pin = 1'b0;
        second_pin = 1'b0;
    end
    // ==========================================================
    // pin drivers
    // levels last over two sampling clocks so no edge is lost
    task automatic set_level(input logic sel, input logic lvl,
        input int hold);
        int n;
        n = (hold < 3) ? 3 : hold;
        @(posedge clk);
        if (sel)
            second_pin <= lvl;
        else
            first_pin <= lvl;
        repeat (n) @(posedge clk);
    endtask
    // one-cycle spike, only when a noise scenario asks for it
    task automatic glitch(input logic sel);
        @(posedge clk);
        if (sel)
            second_pin <= ~second_pin;
        else
            first_pin <= ~first_pin;
        @(posedge clk);
        if (sel)
            second_pin <= ~second_pin;
        else
            first_pin <= ~first_pin;
        repeat (4) @(posedge clk);
    endtask
endmodule // topc_pin_src

// File: verification/test_timer_output_and_prescaler_ctrl.sv
module test_timer_output_and_prescaler_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    topc_pkg::topc_bus_t bus = '0;
    topc_pkg::topc_evt_t evt = '0;
    logic [2:0] mode = 3'h0;
    logic [7:0] rdata, pdir;
    logic pin_out, oe_n, cnt_en, fe, se, p1, p2, shared;
    int n_fail = 0, compares = 0, cyc = 0, m_ff = 0, armed = 0;
    int cnt[3] = '{0, 0, 0};
    int base[3];
    logic [7:0] m_oc = 8'h00;
    always #5 clk = ~clk;
    assign shared = oe_n ? p2 : pin_out;
    topc_ctrl #(.DIV_A(4), .DIV_B(16)) uut
    (
        .CLK(clk), .SRST(srst), .BUS(bus), .RDATA(rdata),
        .MODE_FIELD(mode), .EVT(evt), .FIRST_PIN(p1),
        .SHARED_PIN_IN(shared), .SHARED_PIN_OUT(pin_out),
        .SHARED_PIN_OE_N(oe_n), .PORT_DIR(pdir), .COUNT_EN(cnt_en),
        .FIRST_EDGE(fe), .SECOND_EDGE(se)
    );
    topc_pin_src src (.clk(clk), .first_pin(p1), .second_pin(p2));
    // ==========================================================
    // pulse counters and hang guard
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        cnt[0] <= cnt[0] + int'(cnt_en === 1'b1);
        cnt[1] <= cnt[1] + int'(fe === 1'b1);
        cnt[2] <= cnt[2] + int'(se === 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            wrap_up();
        end
    end
    function automatic int diff(input int k);
        return cnt[k] - base[k];
    endfunction
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk_reg(input logic [15:0] a, input logic [7:0] e,
        input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED reg %h expected %h seen %h", a, e, g);
        end
    endtask
    task automatic chk_pin(input string n, input logic e, input logic g);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk_cnt(input string n, input int e, input int g);
        compares++;
        if (g != e)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask
    // ==========================================================
    // bus and stimulus helpers
    task automatic bus_op(input logic w, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        bus <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1 q = rdata;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus_op(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] q;
        bus_op(1'b0, a, 8'h00, q);
        chk_reg(a, e, q);
    endtask
    task automatic run(input logic [2:0] m);
        @(posedge clk);
        mode <= m;
        #1 base = cnt;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1 chk_pin("pin", m_oc[0] && m_ff, shared);
    endtask
    task automatic oc_wr(input logic [7:0] v);
        wr(16'hff63, v);
        if (v[3:2] == 2'h2) m_ff = 1;
        if (v[3:2] == 2'h1) m_ff = 0;
        if (v[6]) armed = m_oc[5] && mode[2:1] inside {2'h1, 2'h2};
        m_oc = v & 8'h33;
        rd_chk(16'hff63, m_oc);
        settle();
    endtask
    task automatic ev(input logic f, input logic s);
        @(posedge clk);
        evt <= '{match_first: f, match_second: s, overflow: 1'b0};
        @(posedge clk);
        evt <= '0;
        if (m_oc[5] && armed && f && m_oc[1])
        begin
            m_ff = 1;
            armed = 0;
        end
        else if (m_oc[5] && s && m_oc[4])
            m_ff = 0;
        if (!m_oc[5]) m_ff ^= (f && m_oc[1]) ^ (s && m_oc[4]);
        settle();
    endtask
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    // main sequence; every write below except the one-shot trigger writes is made with the timer stopped
    initial
    begin
        logic [7:0] v;
        logic [1:0] c;
        static logic [1:0] codes [3] = '{2'h0, 2'h1, 2'h3};
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        rd_chk(16'hff22, 8'hff);
        rd_chk(16'hff61, 8'h00);
        rd_chk(16'hff63, 8'h00);
        rd_chk(16'hff60, 8'h00);
        $display("test reset finished");
        v = 8'h37;
        repeat (4)
        begin
            v = lfsr(v);
            if (v[7:6] == 2'h2) v[6] = 1'b1;
            if (v[5:4] == 2'h2) v[4] = 1'b1;
            wr(16'hff61, v);
            rd_chk(16'hff61, v & 8'hf3);
            wr(16'hff22, v);
            rd_chk(16'hff22, v | 8'hf0);
            chk_pin("dir", v[1], oe_n);
            chk_reg(16'hff22, v | 8'hf0, pdir);
        end
        wr(16'hff22, 8'hff);
        $display("test registers finished");
        for (int k = 0; k < 3; k++)
        begin
            wr(16'hff61, 8'(k));
            run(3'h2);
            repeat (64) @(posedge clk);
            #1;
            chk_cnt("ticks", 64 / (k == 0 ? 1 : k == 1 ? 4 : 16),
                diff(0));
            run(3'h0);
        end
        wr(16'hff61, 8'h33);
        run(3'h2);
        repeat (2) src.set_level(1'b0, 1'b1, 4);
        repeat (2) src.set_level(1'b0, 1'b0, 4);
        repeat (10) @(posedge clk);
        chk_cnt("pin ticks", 2, diff(0));
        run(3'h0);
        $display("test count clock finished");
        for (int p = 0; p < 2; p++)
            foreach (codes[i])
            begin
                c = codes[i];
                wr(16'hff61, p ? {c, 6'h00} : {2'h0, c, 4'h0});
                run(3'h2);
                src.glitch(p[0]);
                src.set_level(p[0], 1'b1, 4);
                src.set_level(p[0], 1'b0, 4);
                repeat (10) @(posedge clk);
                chk_cnt("edges", (c == 2'h3) ? 2 : 1, diff(p + 1));
                chk_cnt("other", 0, diff(2 - p));
                run(3'h0);
            end
        for (int k = 0; k < 2; k++)
        begin
            wr(16'hff61, k ? 8'h00 : 8'h10);
            src.set_level(1'b0, !k[0], 5);
            run(3'h2);
            repeat (10) @(posedge clk);
            chk_cnt("start edge", 1, diff(1));
            run(3'h0);
        end
        $display("test edges finished");
        wr(16'hff22, 8'h00);
        chk_pin("dir", 1'b0, oe_n);
        oc_wr(8'h08);
        oc_wr(8'h09);
        oc_wr(8'h05);
        oc_wr(8'h13);
        run(3'h2);
        ev(1'b1, 1'b0);
        ev(1'b0, 1'b1);
        ev(1'b1, 1'b1);
        run(3'h0);
        oc_wr(8'h01);
        run(3'h2);
        ev(1'b1, 1'b1);
        run(3'h0);
        $display("test toggle finished");
        oc_wr(8'h37);
        run(3'h2);
        ev(1'b1, 1'b0);
        oc_wr(8'h73);
        ev(1'b1, 1'b0);
        ev(1'b0, 1'b1);
        ev(1'b1, 1'b0);
        run(3'h6);
        repeat (4) @(posedge clk);
        oc_wr(8'h73);
        ev(1'b1, 1'b0);
        run(3'h0);
        $display("test one-shot finished");
        wrap_up();
    end
endmodule // test_timer_output_and_prescaler_ctrl
